// ===== design/ikw_pkg.sv
// Operation
// - non-maskable requests ignore global enable and beat every maskable request
// - any pending request not masked by its mask flag raises the standby release output
// - key wakeup is the external non-maskable source, vector 0002h
// - watchdog overflow in watchdog mode is non-maskable, vector 0004h
// - five maskable sources resolved by fixed priority, level 0 highest
// - watchdog overflow in interval mode is maskable at level 0
// - timer a match is maskable level 1, vector 0006h
// - timer b match is maskable level 2, vector 0008h
// - low voltage request is maskable level 3, vector 000ah
// - nvm write done is maskable level 4, vector 000ch
// - each maskable source owns one request flag and one mask flag
// - in stop mode a falling key edge raises key wakeup
// - key wakeup is unmaskable and acts only in stop mode
// - key edges detected on the combined level of all four keys
// - maskable accepted only with flag set, mask clear, global enable set
// - acknowledge clears the winning source's request flag
// - reset clears all request flags and sets all mask flags
package ikw_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [15:0] ADDR_REQ_FLAGS  = 16'hffe0;
	localparam logic [15:0] ADDR_MASK_FLAGS = 16'hffe4;
	localparam logic [15:0] ADDR_CTRL       = 16'hffe8;
	localparam logic [15:0] ADDR_EVT_STATUS = 16'hffec;
	localparam logic [15:0] ADDR_EVT_MASK   = 16'hfff0;

	localparam logic [4:0] REQ_FLAGS_RST  = 5'h00;
	localparam logic [4:0] MASK_FLAGS_RST = 5'h1f;
	localparam logic [2:0] REQ_PAD        = 3'h0;
	localparam logic [2:0] MASK_PAD       = 3'h7;
	localparam int         CTRL_IE_BIT    = 0;
	localparam int         CTRL_WDTIV_BIT = 1;
	localparam int         EVT_KEY_BIT    = 0;
	localparam int         EVT_WDT_BIT    = 1;

	// ----------------------------------------
	// sources and vectors
	// ----------------------------------------
	localparam logic [2:0] SRC_KEY     = 3'h0;
	localparam logic [2:0] SRC_WDT_NMI = 3'h1;
	localparam logic [2:0] SRC_MASK0   = 3'h2;
	localparam int         NUM_MASK    = 5;
	localparam int         KEY_SLOTS   = 4;

	localparam logic [6:0][15:0] VECTORS = {
		16'h000c, 16'h000a, 16'h0008, 16'h0006, 16'h0004, 16'h0004, 16'h0002};

	typedef struct packed {
		logic wdtOverflow;
		logic timerAMatch;
		logic timerBMatch;
		logic lowVoltage;
		logic nvmWriteDone;
	} ikw_src_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] vector;
	} ikw_cpu_t;

	typedef struct packed {
		logic [4:0] reqFlags;
		logic [4:0] maskFlags;
		logic       globalIrqEnable;
		logic       wdtInterval;
		logic       keyNmi;
		logic       wdtNmi;
		logic [KEY_SLOTS-1:0] keyMeta;
		logic [KEY_SLOTS-1:0] keySync;
		logic       keyLevel;
		logic       lvPrev;
		logic [1:0] evtStatus;
		logic [1:0] evtMask;
		logic [7:0] rdata;
		logic       valid;
		logic [2:0] sel;
		logic [15:0] vector;
	} ikw_state_t;

endpackage

// ===== design/ikw_key_irq.sv
`timescale 1ns/1ps
`default_nettype none
module ikw_key_irq #(
	parameter int KEYS = 4
) (
	input  wire logic              mclk,
	input  wire logic              resetn,
	input  wire logic [15:0]       regAddr,
	input  wire logic [7:0]        regWdata,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic [7:0]             regRdata,
	input  wire logic [KEYS-1:0]   keyIn,
	input  wire logic              stopMode,
	input  wire ikw_pkg::ikw_src_t src,
	input  wire logic              irqAck,
	output ikw_pkg::ikw_cpu_t      cpuReq,
	output logic                   standbyRelease,
	output logic                   eventIrq
);
	import ikw_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	ikw_state_t s_q;
	ikw_state_t s_d;
	logic       keyFall;
	logic       keyEvt;
	logic       wdtNmiEvt;
	logic       lvRise;
	logic [4:0] maskEvt;
	logic [4:0] enabled;
	logic [2:0] mIdx;

	if (KEYS < 1 || KEYS > KEY_SLOTS)
	begin : g_chk
		$error("ikw_key_irq needs one to four key inputs");
	end

	assign keyFall   = s_q.keyLevel & ~(&s_q.keySync);
	assign keyEvt    = keyFall & stopMode;
	assign wdtNmiEvt = src.wdtOverflow & ~s_q.wdtInterval;
	assign lvRise    = src.lowVoltage & ~s_q.lvPrev;
	assign maskEvt   = {src.nvmWriteDone, lvRise, src.timerBMatch, src.timerAMatch,
		src.wdtOverflow & s_q.wdtInterval};

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		logic [4:0] pend;
		pend = 5'h00;
		s_d = s_q;
		// each key pin through two flops, then combined
		s_d.keyMeta = '1;
		s_d.keyMeta[KEYS-1:0] = keyIn;
		s_d.keySync = s_q.keyMeta;
		s_d.keyLevel = &s_q.keySync;
		s_d.lvPrev = src.lowVoltage;
		if (irqAck && s_q.valid)
		begin
			s_d.globalIrqEnable = 1'b0;
			unique case (s_q.sel)
				SRC_KEY:     s_d.keyNmi = 1'b0;
				SRC_WDT_NMI: s_d.wdtNmi = 1'b0;
				default:     s_d.reqFlags[s_q.sel - SRC_MASK0] = 1'b0;
			endcase
		end
		if (regWr)
		begin
			unique case (regAddr)
				ADDR_REQ_FLAGS:  s_d.reqFlags = regWdata[4:0];
				ADDR_MASK_FLAGS: s_d.maskFlags = regWdata[4:0];
				ADDR_CTRL:
				begin
					s_d.globalIrqEnable = regWdata[CTRL_IE_BIT];
					s_d.wdtInterval = regWdata[CTRL_WDTIV_BIT];
				end
				ADDR_EVT_STATUS: s_d.evtStatus = s_q.evtStatus & ~regWdata[1:0];
				ADDR_EVT_MASK:   s_d.evtMask = regWdata[1:0];
				default:         s_d.rdata = s_d.rdata;
			endcase
		end
		s_d.reqFlags = s_d.reqFlags | maskEvt;
		s_d.keyNmi = s_d.keyNmi | keyEvt;
		s_d.wdtNmi = s_d.wdtNmi | wdtNmiEvt;
		s_d.evtStatus[EVT_KEY_BIT] = s_d.evtStatus[EVT_KEY_BIT] | keyEvt;
		s_d.evtStatus[EVT_WDT_BIT] = s_d.evtStatus[EVT_WDT_BIT] | wdtNmiEvt;
		// arbitration
		pend = s_d.reqFlags & ~s_d.maskFlags & {5{s_d.globalIrqEnable}};
		s_d.valid = 1'b0;
		s_d.sel = SRC_KEY;
		for (int i = NUM_MASK - 1; i >= 0; i--)
		begin
			if (pend[i])
			begin
				s_d.valid = 1'b1;
				s_d.sel = SRC_MASK0 + 3'(i);
			end
		end
		if (s_d.wdtNmi)
		begin
			s_d.valid = 1'b1;
			s_d.sel = SRC_WDT_NMI;
		end
		if (s_d.keyNmi)
		begin
			s_d.valid = 1'b1;
			s_d.sel = SRC_KEY;
		end
		s_d.vector = VECTORS[s_d.sel];
		// read port
		s_d.rdata = 8'h00;
		if (regRd)
		begin
			unique case (regAddr)
				ADDR_REQ_FLAGS:  s_d.rdata = {REQ_PAD, s_q.reqFlags};
				ADDR_MASK_FLAGS: s_d.rdata = {MASK_PAD, s_q.maskFlags};
				ADDR_CTRL:       s_d.rdata = {6'h00, s_q.wdtInterval, s_q.globalIrqEnable};
				ADDR_EVT_STATUS: s_d.rdata = {6'h00, s_q.evtStatus};
				ADDR_EVT_MASK:   s_d.rdata = {6'h00, s_q.evtMask};
				default:         s_d.rdata = 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_q <= '0;
			s_q.reqFlags <= REQ_FLAGS_RST;
			s_q.maskFlags <= MASK_FLAGS_RST;
			s_q.keyMeta <= '1;
			s_q.keySync <= '1;
			s_q.keyLevel <= 1'b1;
			s_q.vector <= 16'h0002;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign enabled = s_q.reqFlags & ~s_q.maskFlags;
	assign regRdata = s_q.rdata;
	assign cpuReq.valid = s_q.valid;
	assign cpuReq.vector = s_q.vector;
	assign standbyRelease = (|enabled) | s_q.keyNmi | s_q.wdtNmi;
	assign eventIrq = |(s_q.evtStatus & s_q.evtMask);
	assign mIdx = s_q.sel - SRC_MASK0;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	nmi_wins_a: assert property ((s_q.keyNmi || s_q.wdtNmi) |->
		s_q.valid && s_q.sel <= SRC_WDT_NMI)
		else $error("nmi pending but not presented");
	mask_gate_a: assert property ((s_q.valid && s_q.sel >= SRC_MASK0) |->
		s_q.globalIrqEnable && s_q.reqFlags[mIdx] && !s_q.maskFlags[mIdx])
		else $error("maskable request presented while gated");
	priority_order_a: assert property ((s_q.valid && s_q.sel >= SRC_MASK0) |->
		(enabled & ((5'h01 << mIdx) - 5'h01)) == 5'h00)
		else $error("lower priority maskable won");
	standby_wake_a: assert property ((s_q.keyNmi || |enabled) |-> standbyRelease)
		else $error("pending request without standby release");
	key_vector_a: assert property ((s_q.valid && s_q.sel == SRC_KEY) |->
		cpuReq.vector == 16'h0002)
		else $error("key wakeup vector wrong");
	key_stop_only_a: assert property ($rose(s_q.keyNmi) |-> $past(stopMode))
		else $error("key wakeup raised outside stop");
	key_edge_a: assert property ($rose(s_q.keyNmi) |->
		$past(s_q.keyLevel) && !$past(&s_q.keySync))
		else $error("key wakeup without combined fall");
	wdt_route_a: assert property ($rose(s_q.wdtNmi) |-> !$past(s_q.wdtInterval))
		else $error("watchdog nmi in interval mode");
	ack_clear_a: assert property ((irqAck && s_q.valid && s_q.sel >= SRC_MASK0 &&
		!maskEvt[mIdx] && !(regWr && regAddr == ADDR_REQ_FLAGS) &&
		!(regWr && regAddr == ADDR_CTRL)) |=>
		!s_q.reqFlags[$past(mIdx)] && !s_q.globalIrqEnable)
		else $error("acknowledge did not clear flag");

endmodule // ikw_key_irq
`default_nettype wire

// ===== testbench/ikw_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// cpu acknowledge model
// ------------------------------
module ikw_cpu_model (
	input  wire logic              mclk,
	input  wire logic              resetn,
	input  wire ikw_pkg::ikw_cpu_t cpuReq,
	input  wire logic              ackEn,
	input  wire logic              slow,
	output logic                   irqAck,
	output logic [15:0]            lastVec,
	output logic [7:0]             ackCnt
);
	import ikw_pkg::*;
	logic [1:0] waitQ;
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			irqAck  <= 1'b0;
			waitQ   <= 2'h0;
			lastVec <= 16'h0000;
			ackCnt  <= 8'h00;
		end
		else if (irqAck)
		begin
			irqAck  <= 1'b0;
			lastVec <= cpuReq.vector;
			ackCnt  <= ackCnt + 8'h01;
		end
		else if (ackEn && cpuReq.valid)
		begin
			irqAck <= !slow || waitQ == 2'h3;
			waitQ  <= waitQ + 2'h1;
		end
		else
			waitQ <= 2'h0;
	end
endmodule // ikw_cpu_model
`default_nettype wire

// ===== testbench/interrupt_and_key_wakeup_tb.sv
`timescale 1ns/1ps
`default_nettype none
module interrupt_and_key_wakeup_tb;
	import ikw_pkg::*;
	logic        mclk = 1'b0;
	logic        resetn = 1'b0;
	logic [15:0] regAddr = 16'h0000;
	logic [7:0]  regWdata = 8'h00;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [7:0]  regRdata;
	logic [3:0]  keyIn = 4'hf;
	logic        stopMode = 1'b0;
	ikw_src_t    src = '0;
	logic        irqAck;
	ikw_cpu_t    cpuReq;
	logic        standbyRelease;
	logic        eventIrq;
	logic        ackEn = 1'b0;
	logic        slow = 1'b0;
	logic [15:0] lastVec;
	logic [7:0]  ackCnt;
	logic [7:0]  rv;
	int          failures = 0;
	int          n_tests = 0;
	ikw_key_irq i_ikw_key_irq (.mclk, .resetn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
		.keyIn, .stopMode, .src, .irqAck, .cpuReq, .standbyRelease, .eventIrq);
	ikw_cpu_model i_ikw_cpu_model (.mclk, .resetn, .cpuReq, .ackEn, .slow, .irqAck, .lastVec,
		.ackCnt);
	always #50 mclk = ~mclk;
	// ------------------------------
	// helpers
	// ------------------------------
	function automatic logic [15:0] vecOf(input int lvl);
		return (lvl == 0) ? 16'h0004 : 16'h0004 + 16'(2 * lvl);
	endfunction
	task report_and_stop();
		if (failures == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
		@(posedge mclk);
		#1;
	endtask
	task rd(input logic [15:0] a, input logic [7:0] exp);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		#1;
		chk(16'(regRdata), 16'(exp));
	endtask
	task pulse(input ikw_src_t v);
		src <= v;
		@(posedge mclk);
		src <= v & 5'h02;
		repeat (2) @(posedge mclk);
		#1;
	endtask
	task waitAck(input logic [15:0] exp);
		logic [7:0] c0;
		int         n;
		c0 = ackCnt;
		n = 0;
		while (ackCnt === c0 && n < 60)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (ackCnt === c0)
		begin
			failures++;
			report_and_stop();
		end
		chk(lastVec, exp);
	endtask
	task quiet(input logic [3:0] k);
		rv = ackCnt;
		keyIn <= k;
		repeat (8) @(posedge mclk);
		#1;
		chk(16'(ackCnt), 16'(rv));
		keyIn <= 4'hf;
		repeat (4) @(posedge mclk);
		#1;
	endtask
	// ------------------------------
	// scenarios
	// ------------------------------
	initial
	begin
		repeat (20000) @(posedge mclk);
		failures++;
		report_and_stop();
	end
	initial
	begin
		void'($urandom(9));
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		#1;
		rd(ADDR_REQ_FLAGS, 8'h00);
		rd(ADDR_MASK_FLAGS, 8'hff);
		repeat (4)
		begin
			rv = 8'($urandom);
			wr(ADDR_MASK_FLAGS, rv);
			rd(ADDR_MASK_FLAGS, rv | 8'he0);
		end
		wr(ADDR_MASK_FLAGS, 8'h00);
		wr(ADDR_CTRL, 8'h03);
		pulse(5'h1f);
		chk(16'(standbyRelease), 16'h1);
		rd(ADDR_REQ_FLAGS, 8'h1f);
		ackEn <= 1'b1;
		for (int k = 0; k < 5; k++)
		begin
			slow <= k[0];
			waitAck(vecOf(k));
			wr(ADDR_CTRL, 8'h03);
		end
		rd(ADDR_REQ_FLAGS, 8'h00);
		ackEn <= 1'b0;
		src <= '0;
		wr(ADDR_CTRL, 8'h00);
		pulse(5'h08);
		chk(16'(cpuReq.valid), 16'h0);
		chk(16'(standbyRelease), 16'h1);
		pulse(5'h10);
		chk(16'(cpuReq.valid), 16'h1);
		chk(cpuReq.vector, 16'h0004);
		wr(ADDR_EVT_MASK, 8'h00);
		chk(16'(eventIrq), 16'h0);
		wr(ADDR_EVT_MASK, 8'h03);
		chk(16'(eventIrq), 16'h1);
		wr(ADDR_EVT_STATUS, 8'h02);
		chk(16'(eventIrq), 16'h0);
		wr(ADDR_CTRL, 8'h01);
		ackEn <= 1'b1;
		waitAck(16'h0004);
		wr(ADDR_CTRL, 8'h01);
		waitAck(16'h0006);
		rd(ADDR_CTRL, 8'h00);
		stopMode <= 1'b1;
		for (int k = 0; k < 4; k++)
		begin
			keyIn <= ~(4'h1 << k);
			waitAck(16'h0002);
			quiet(~(4'h3 << k));
		end
		rd(ADDR_EVT_STATUS, 8'h01);
		chk(16'(eventIrq), 16'h1);
		stopMode <= 1'b0;
		quiet(4'h7);
		report_and_stop();
	end
endmodule // interrupt_and_key_wakeup_tb
`default_nettype wire
